// ---- design/autoneg_np_pkg.sv ----
package autoneg_np_pkg;

	// Register offsets on the management register port.
	localparam logic [4:0]  OFS_PARTNER_BASE_ABILITY     = 5'h05;
	localparam logic [4:0]  OFS_NEGOTIATION_EXPANSION    = 5'h06;
	localparam logic [4:0]  OFS_LOCAL_NEXT_PAGE_WORD     = 5'h07;

	// Partner base ability field positions.
	localparam int unsigned PBA_NEXT_PAGE_BIT            = 15;
	localparam int unsigned PBA_ACK_BIT                  = 14;
	localparam int unsigned PBA_REMOTE_FAULT_BIT         = 13;
	localparam int unsigned PBA_ASYM_PAUSE_BIT           = 11;
	localparam int unsigned PBA_PAUSE_BIT                = 10;
	localparam int unsigned PBA_T4_BIT                   = 9;
	localparam int unsigned PBA_TX_FD_BIT                = 8;
	localparam int unsigned PBA_TX_HD_BIT                = 7;
	localparam int unsigned PBA_TE_FD_BIT                = 6;
	localparam int unsigned PBA_TE_HD_BIT                = 5;
	localparam int unsigned PBA_SELECTOR_MSB             = 4;
	localparam logic [15:0] PBA_RESET                    = 16'h0000;
	localparam logic [15:0] PBA_IMPLEMENTED_MASK         = 16'hefff;
	localparam logic [4:0]  SELECTOR_IEEE_8023           = 5'h01;

	// Expansion status field positions.
	localparam int unsigned EXP_PARALLEL_FAULT_BIT       = 4;
	localparam int unsigned EXP_PARTNER_NP_ABLE_BIT      = 3;
	localparam int unsigned EXP_LOCAL_NP_ABLE_BIT        = 2;
	localparam int unsigned EXP_PAGE_RECEIVED_BIT        = 1;
	localparam int unsigned EXP_PARTNER_AN_ABLE_BIT      = 0;
	localparam logic        LOCAL_NP_ABLE                = 1'b1;
	localparam logic        LATCHED_HIGH_RESET           = 1'b0;

	// Local next page word field positions.
	localparam int unsigned NP_NEXT_PAGE_BIT             = 15;
	localparam int unsigned NP_MESSAGE_PAGE_BIT          = 13;
	localparam int unsigned NP_COMPLY_ACK_BIT            = 12;
	localparam int unsigned NP_TOGGLE_BIT                = 11;
	localparam int unsigned NP_CODE_MSB                  = 10;
	localparam logic [15:0] NP_RESET                     = 16'h2001;
	localparam logic [15:0] NP_WRITE_MASK                = 16'hb7ff;
	localparam logic [10:0] NP_NULL_MESSAGE_CODE         = 11'h001;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} mgmt_req_t;

	typedef struct packed {
		logic [15:0] data;
		logic        valid;
	} mgmt_rsp_t;

	typedef struct packed {
		logic        page_valid;
		logic [15:0] page;
		logic        page_received;
		logic        parallel_fault;
		logic        partner_np_able;
		logic        partner_an_able;
		logic        lcw_exchanged;
		logic        lcw_toggle;
	} an_status_t;

	typedef struct packed {
		logic q;
	} latched_high_t;

	typedef struct packed {
		logic [15:0] partner_ability;
		logic        partner_np_able;
		logic        partner_an_able;
		logic [15:0] next_page_word;
		logic [15:0] rdata;
		logic        rvalid;
	} np_regs_t;

endpackage

// ---- design/latched_high_bit.sv ----
`timescale 1ns/100ps
`default_nettype none

// Sticky status bit: an event sets it, a read clears it, and a set in the
// same cycle as the clear wins so that no event is lost.
module latched_high_bit
	import autoneg_np_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Control
	input  wire logic set_event,
	input  wire logic clear_on_read,
	// Status
	output logic      q
);

	latched_high_t s_reg;
	latched_high_t s_next;

	always_comb
	begin
		s_next = s_reg;
		if (set_event)
		begin
			s_next.q = 1'b1;
		end
		else if (clear_on_read)
		begin
			s_next.q = 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s_reg.q <= LATCHED_HIGH_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.q;

endmodule
`default_nettype wire

// ---- design/autoneg_partner_nextpage_regs.sv ----
// Functional notes
// - Partner bit 15 shows partner next-page request.
// - Partner bit 14 shows partner acknowledge.
// - Partner bit 13 shows partner remote fault.
// - Partner bits 11/10 show asymmetric, symmetric pause.
// - Partner bits 9:5 show advertised technologies.
// - Partner bits 4:0 hold selector, reset zero.
// - Expansion bit 4 latches parallel detection fault.
// - Expansion bit 3 shows partner next-page ability.
// - Expansion bit 2 always reads one.
// - Expansion bit 1 latches new page received.
// - Expansion bit 0 shows partner autoneg ability.
// - Next-page bit 15 requests further pages.
// - Next-page bit 13 selects message page, reset one.
// - Next-page bit 12 is comply acknowledge.
// - Toggle bit 11 inverts previous exchanged toggle.
// - Bits 10:0 carry the transmitted code field.
// - Code field resets to null message value one.
// - Latched bits clear on read or reset.
`timescale 1ns/100ps
`default_nettype none

module autoneg_partner_nextpage_regs
	import autoneg_np_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         reset,
	// Management register port
	input  wire mgmt_req_t    mgmt_req,
	output mgmt_rsp_t         mgmt_rsp,
	// Arbitration engine status
	input  wire an_status_t   an_status,
	// Page word handed to the arbitration engine
	output logic [15:0]       tx_next_page_word
);

	np_regs_t    s_reg;
	np_regs_t    s_next;
	logic        parallel_fault_q;
	logic        page_received_q;
	logic        rd_expansion;
	logic [15:0] expansion_word;
	logic        rd_partner;
	logic        rd_next_page;
	logic        wr_next_page;

	assign rd_expansion = mgmt_req.rd && (mgmt_req.addr == OFS_NEGOTIATION_EXPANSION);
	assign rd_partner   = mgmt_req.rd && (mgmt_req.addr == OFS_PARTNER_BASE_ABILITY);
	assign rd_next_page = mgmt_req.rd && (mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD);
	assign wr_next_page = mgmt_req.wr && (mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD);

	latched_high_bit u_parallel_fault (
		.clk_sys       (clk_sys),
		.reset         (reset),
		.set_event     (an_status.parallel_fault),
		.clear_on_read (rd_expansion),
		.q             (parallel_fault_q)
	);

	latched_high_bit u_page_received (
		.clk_sys       (clk_sys),
		.reset         (reset),
		.set_event     (an_status.page_received),
		.clear_on_read (rd_expansion),
		.q             (page_received_q)
	);

	always_comb
	begin
		expansion_word                          = 16'h0000;
		expansion_word[EXP_PARALLEL_FAULT_BIT]  = parallel_fault_q;
		expansion_word[EXP_PARTNER_NP_ABLE_BIT] = s_reg.partner_np_able;
		expansion_word[EXP_LOCAL_NP_ABLE_BIT]   = LOCAL_NP_ABLE;
		expansion_word[EXP_PAGE_RECEIVED_BIT]   = page_received_q;
		expansion_word[EXP_PARTNER_AN_ABLE_BIT] = s_reg.partner_an_able;
	end

	always_comb
	begin
		s_next        = s_reg;
		s_next.rvalid = 1'b0;
		s_next.partner_np_able = an_status.partner_np_able;
		s_next.partner_an_able = an_status.partner_an_able;
		// The whole received base page is captured at once; reserved bit 12 is dropped.
		if (an_status.page_valid)
		begin
			s_next.partner_ability = an_status.page & PBA_IMPLEMENTED_MASK;
		end
		// Only the writable fields take software data; toggle and bit 14 keep their value.
		if (mgmt_req.wr && (mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD))
		begin
			s_next.next_page_word = (mgmt_req.wdata & NP_WRITE_MASK)
				| (s_reg.next_page_word & ~NP_WRITE_MASK);
		end
		if (an_status.lcw_exchanged)
		begin
			s_next.next_page_word[NP_TOGGLE_BIT] = ~an_status.lcw_toggle;
		end
		if (mgmt_req.rd)
		begin
			s_next.rvalid = 1'b1;
			if (mgmt_req.addr == OFS_PARTNER_BASE_ABILITY)
			begin
				s_next.rdata = s_reg.partner_ability;
			end
			else if (mgmt_req.addr == OFS_NEGOTIATION_EXPANSION)
			begin
				s_next.rdata = expansion_word;
			end
			else if (mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD)
			begin
				s_next.rdata = s_reg.next_page_word;
			end
			else
			begin
				s_next.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s_reg.partner_ability <= PBA_RESET;
			s_reg.partner_np_able <= 1'b0;
			s_reg.partner_an_able <= 1'b0;
			s_reg.next_page_word  <= NP_RESET;
			s_reg.rdata           <= 16'h0000;
			s_reg.rvalid          <= 1'b0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign mgmt_rsp.data      = s_reg.rdata;
	assign mgmt_rsp.valid     = s_reg.rvalid;
	assign tx_next_page_word  = s_reg.next_page_word;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_read_answer_latency: assert property (
		mgmt_req.rd |=> mgmt_rsp.valid)
		else $error("Read not answered one cycle later.");

	a_answer_needs_read: assert property (
		mgmt_rsp.valid |-> $past(mgmt_req.rd))
		else $error("Answer without a read.");

	a_fault_latches: assert property (
		an_status.parallel_fault |=> parallel_fault_q)
		else $error("Parallel fault flag did not latch.");

	a_read_clears_flag: assert property (
		rd_expansion && !an_status.page_received && !an_status.parallel_fault
		|=> !page_received_q && !parallel_fault_q)
		else $error("Read did not clear latched flags.");

	a_page_rx_reported: assert property (
		page_received_q && rd_expansion |=> mgmt_rsp.data[EXP_PAGE_RECEIVED_BIT])
		else $error("Page received event lost before read.");

	a_expansion_fixed: assert property (
		rd_expansion |=> mgmt_rsp.data[EXP_LOCAL_NP_ABLE_BIT] && mgmt_rsp.data[15:5] == 11'h000)
		else $error("Expansion fixed or reserved bits wrong.");

	a_partner_capture: assert property (
		an_status.page_valid |=> s_reg.partner_ability == ($past(an_status.page) & PBA_IMPLEMENTED_MASK))
		else $error("Partner page not captured.");

	a_partner_ro_write: assert property (
		mgmt_req.wr && !an_status.page_valid |=> $stable(s_reg.partner_ability))
		else $error("Write altered read-only partner register.");

	a_toggle_inverse: assert property (
		an_status.lcw_exchanged |=> tx_next_page_word[NP_TOGGLE_BIT] == !$past(an_status.lcw_toggle))
		else $error("Toggle does not invert exchanged toggle.");

	a_np_write_fields: assert property (
		mgmt_req.wr && mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD
		|=> (tx_next_page_word & NP_WRITE_MASK) == ($past(mgmt_req.wdata) & NP_WRITE_MASK)
		&& !tx_next_page_word[14])
		else $error("Next page write fields wrong.");

	a_np_reset_value: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		reset |=> tx_next_page_word == NP_RESET)
		else $error("Next page word reset value wrong.");

	a_partner_np_bit: assert property (
		an_status.page_valid
		|=> s_reg.partner_ability[PBA_NEXT_PAGE_BIT] == $past(an_status.page[PBA_NEXT_PAGE_BIT]))
		else $error("Partner next page bit not captured.");

	a_partner_ack_bit: assert property (
		an_status.page_valid
		|=> s_reg.partner_ability[PBA_ACK_BIT] == $past(an_status.page[PBA_ACK_BIT]))
		else $error("Partner acknowledge bit not captured.");

	a_partner_fault_bit: assert property (
		an_status.page_valid
		|=> s_reg.partner_ability[PBA_REMOTE_FAULT_BIT] == $past(an_status.page[PBA_REMOTE_FAULT_BIT]))
		else $error("Partner remote fault bit not captured.");

	a_partner_pause_bits: assert property (
		an_status.page_valid |=> s_reg.partner_ability[PBA_ASYM_PAUSE_BIT:PBA_PAUSE_BIT]
		== $past(an_status.page[PBA_ASYM_PAUSE_BIT:PBA_PAUSE_BIT]))
		else $error("Partner pause bits not captured.");

	a_partner_tech_bits: assert property (
		an_status.page_valid |=> s_reg.partner_ability[PBA_T4_BIT:PBA_TE_HD_BIT]
		== $past(an_status.page[PBA_T4_BIT:PBA_TE_HD_BIT]))
		else $error("Partner technology bits not captured.");

	a_partner_selector: assert property (
		an_status.page_valid |=> s_reg.partner_ability[PBA_SELECTOR_MSB:0]
		== $past(an_status.page[PBA_SELECTOR_MSB:0]))
		else $error("Partner selector not captured.");

	a_partner_reserved: assert property (
		rd_partner
		|=> !mgmt_rsp.data[12])
		else $error("Partner reserved bit reads one.");

	a_partner_holds: assert property (
		!an_status.page_valid
		|=> $stable(s_reg.partner_ability))
		else $error("Partner register changed without a page.");

	a_partner_read: assert property (
		rd_partner
		|=> mgmt_rsp.data == $past(s_reg.partner_ability))
		else $error("Partner register read wrong.");

	a_partner_reset: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		reset |=> s_reg.partner_ability == PBA_RESET && !mgmt_rsp.valid)
		else $error("Partner register reset value wrong.");

	a_fault_holds: assert property (
		parallel_fault_q && !rd_expansion
		|=> parallel_fault_q)
		else $error("Parallel fault flag dropped without a read.");

	a_fault_reported: assert property (
		parallel_fault_q && rd_expansion
		|=> mgmt_rsp.data[EXP_PARALLEL_FAULT_BIT])
		else $error("Parallel fault flag not reported.");

	a_fault_needs_event: assert property (
		!parallel_fault_q && !an_status.parallel_fault
		|=> !parallel_fault_q)
		else $error("Parallel fault flag set without an event.");

	a_np_able_read: assert property (
		rd_expansion && !$past(reset)
		|=> mgmt_rsp.data[EXP_PARTNER_NP_ABLE_BIT] == $past(an_status.partner_np_able, 2))
		else $error("Partner next page ability read wrong.");

	a_an_able_read: assert property (
		rd_expansion && !$past(reset)
		|=> mgmt_rsp.data[EXP_PARTNER_AN_ABLE_BIT] == $past(an_status.partner_an_able, 2))
		else $error("Partner autoneg ability read wrong.");

	a_page_rx_latches: assert property (
		an_status.page_received
		|=> page_received_q)
		else $error("Page received flag did not latch.");

	a_page_rx_holds: assert property (
		page_received_q && !rd_expansion
		|=> page_received_q)
		else $error("Page received flag dropped without a read.");

	a_page_needs_event: assert property (
		!page_received_q && !an_status.page_received
		|=> !page_received_q)
		else $error("Page received flag set without an event.");

	a_set_wins: assert property (
		rd_expansion && an_status.page_received
		|=> page_received_q)
		else $error("Page event lost when it met a clearing read.");

	a_flags_reset: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		reset |=> !parallel_fault_q && !page_received_q)
		else $error("Latched flags not cleared by reset.");

	a_np_bit_sent: assert property (
		wr_next_page
		|=> tx_next_page_word[NP_NEXT_PAGE_BIT] == $past(mgmt_req.wdata[NP_NEXT_PAGE_BIT]))
		else $error("Next page request bit not sent.");

	a_message_page_bit: assert property (
		wr_next_page
		|=> tx_next_page_word[NP_MESSAGE_PAGE_BIT] == $past(mgmt_req.wdata[NP_MESSAGE_PAGE_BIT]))
		else $error("Message page bit not sent.");

	a_comply_ack_bit: assert property (
		wr_next_page
		|=> tx_next_page_word[NP_COMPLY_ACK_BIT] == $past(mgmt_req.wdata[NP_COMPLY_ACK_BIT]))
		else $error("Comply acknowledge bit not sent.");

	a_code_field: assert property (
		wr_next_page
		|=> tx_next_page_word[NP_CODE_MSB:0] == $past(mgmt_req.wdata[NP_CODE_MSB:0]))
		else $error("Next page code field not sent.");

	a_toggle_holds: assert property (
		!an_status.lcw_exchanged
		|=> $stable(tx_next_page_word[NP_TOGGLE_BIT]))
		else $error("Toggle changed without an exchange.");

	a_np_reserved: assert property (
		rd_next_page
		|=> !mgmt_rsp.data[14])
		else $error("Next page reserved bit reads one.");

	a_np_holds: assert property (
		!wr_next_page && !an_status.lcw_exchanged
		|=> $stable(tx_next_page_word))
		else $error("Next page word changed on its own.");

	a_np_read: assert property (
		rd_next_page
		|=> mgmt_rsp.data == $past(tx_next_page_word))
		else $error("Next page word read wrong.");

	a_unmapped_zero: assert property (
		mgmt_req.rd && !rd_partner && !rd_expansion && !rd_next_page
		|=> mgmt_rsp.data == 16'h0000)
		else $error("Unmapped read not zero.");

	a_answer_holds: assert property (
		!mgmt_req.rd
		|=> $stable(mgmt_rsp.data))
		else $error("Read data changed without a read.");

	c_flag_read: cover property (parallel_fault_q && rd_expansion);
	c_set_clear_collide: cover property (an_status.page_received && rd_expansion);
	c_np_write: cover property (mgmt_req.wr && mgmt_req.addr == OFS_LOCAL_NEXT_PAGE_WORD);
	c_lcw_exchange: cover property (an_status.lcw_exchanged ##1 mgmt_req.rd);

endmodule
`default_nettype wire

// ---- tb/mgmt_station_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module mgmt_station_model
	import autoneg_np_pkg::*;
(
	// Clock
	input  wire logic      clk_sys,
	// Management register port
	output var mgmt_req_t  mgmt_req,
	input  wire mgmt_rsp_t mgmt_rsp
);
	initial mgmt_req = '0;

	// Released address and data show a changed pattern, not the last value.
	task release_bus(input logic [4:0] a, input logic [15:0] w);
		mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
	endtask

	task wr(input logic [4:0] a, input logic [15:0] w);
		@(negedge clk_sys);
		mgmt_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
		@(negedge clk_sys);
		release_bus(a, w);
	endtask

	// A missing answer strobe yields unknown data so that the compare fails.
	task rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge clk_sys);
		mgmt_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~mgmt_req.wdata};
		@(negedge clk_sys);
		release_bus(a, mgmt_req.wdata);
		d = (mgmt_rsp.valid === 1'b1) ? mgmt_rsp.data : 16'hxxxx;
	endtask
endmodule

`default_nettype wire

// ---- tb/autoneg_partner_nextpage_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module autoneg_partner_nextpage_regs_tb
	import autoneg_np_pkg::*;
;
	logic        clk_sys;
	logic        reset;
	mgmt_req_t   mgmt_req;
	mgmt_rsp_t   mgmt_rsp;
	an_status_t  an_status;
	logic [15:0] tx_next_page_word;
	logic [1:0]  lvl;
	logic [15:0] d;
	int          num_errors;
	int          n_compared;

	autoneg_partner_nextpage_regs i_autoneg_partner_nextpage_regs (
		.clk_sys           (clk_sys),
		.reset             (reset),
		.mgmt_req          (mgmt_req),
		.mgmt_rsp          (mgmt_rsp),
		.an_status         (an_status),
		.tx_next_page_word (tx_next_page_word)
	);

	mgmt_station_model i_mgmt_station_model (
		.clk_sys  (clk_sys),
		.mgmt_req (mgmt_req),
		.mgmt_rsp (mgmt_rsp)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task end_sim;
		$display("Comparisons %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
		i_mgmt_station_model.rd(a, d);
		chk(what, d, exp);
	endtask

	// Event pulses stand for one rising edge; the two levels stay applied.
	task ev(input logic [22:0] v);
		@(negedge clk_sys);
		an_status = v | {19'h0, lvl, 2'b0};
		@(negedge clk_sys);
		an_status = {19'h0, lvl, 2'b0};
	endtask

	initial
	begin
		repeat (2000) @(posedge clk_sys);
		num_errors++;
		end_sim;
	end

	initial
	begin
		an_status = '0;
		lvl = 2'b00;
		num_errors = 0;
		n_compared = 0;
		reset = 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		chk("tx word reset", tx_next_page_word, 16'h2001);
		rchk("partner reset", 5'h05, 16'h0000);
		rchk("expansion reset", 5'h06, 16'h0004);
		rchk("next page reset", 5'h07, 16'h2001);
		ev({1'b1, 16'hffff, 6'h00});
		rchk("partner all ones", 5'h05, 16'hefff);
		ev({1'b1, 16'h0001, 6'h00});
		rchk("partner selector", 5'h05, 16'h0001);
		i_mgmt_station_model.wr(5'h05, 16'hffff);
		i_mgmt_station_model.wr(5'h06, 16'hffff);
		rchk("partner write", 5'h05, 16'h0001);
		rchk("expansion write", 5'h06, 16'h0004);
		ev({17'h0, 6'h10});
		rchk("fault latched", 5'h06, 16'h0014);
		rchk("fault cleared", 5'h06, 16'h0004);
		ev({17'h0, 6'h20});
		rchk("page received", 5'h06, 16'h0006);
		rchk("page cleared", 5'h06, 16'h0004);
		// A page event in the very cycle of a clearing read must survive it.
		fork
			ev({17'h0, 6'h20});
			rchk("read beside page event", 5'h06, 16'h0004);
		join
		rchk("page event kept", 5'h06, 16'h0006);
		lvl = 2'b10;
		ev('0);
		rchk("partner np able", 5'h06, 16'h000c);
		lvl = 2'b01;
		ev('0);
		rchk("partner an able", 5'h06, 16'h0005);
		lvl = 2'b00;
		i_mgmt_station_model.wr(5'h07, 16'hffff);
		chk("tx word ones", tx_next_page_word, 16'hb7ff);
		rchk("next page ones", 5'h07, 16'hb7ff);
		i_mgmt_station_model.wr(5'h07, 16'h0000);
		rchk("unformatted page", 5'h07, 16'h0000);
		ev({17'h0, 6'h02});
		rchk("toggle after zero", 5'h07, 16'h0800);
		ev({17'h0, 6'h03});
		rchk("toggle after one", 5'h07, 16'h0000);
		i_mgmt_station_model.wr(5'h07, 16'h1555);
		chk("tx code field", tx_next_page_word, 16'h1555);
		rchk("unmapped read", 5'h1f, 16'h0000);
		ev({17'h0, 6'h10});
		@(negedge clk_sys);
		reset = 1'b1;
		@(negedge clk_sys);
		reset = 1'b0;
		rchk("fault after reset", 5'h06, 16'h0004);
		chk("tx word again", tx_next_page_word, 16'h2001);
		end_sim;
	end
endmodule

`default_nettype wire
